// file: inc/msi_pkg.sv
// shared constants and carriers for the modem status input block
package msi_pkg;

    // two serial ports, each with its own copy of the logic
    localparam int NPORT = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register offsets: per-port group repeats every PORT_STRIDE bytes
    localparam logic [ADDR_W-1:0] OFS_IER      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MCR      = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MSR      = 8'h08;
    localparam logic [ADDR_W-1:0] PORT_STRIDE  = 8'h10;
    localparam logic [ADDR_W-1:0] PORT_SPAN    = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h24;
    localparam int PORT_IDX_LSB = 4;
    localparam int REG_OFS_W    = 4;

    // field widths and positions
    localparam int IER_W        = 4;
    localparam int IER_MSI_BIT  = 3;
    localparam int MCR_W        = 5;
    localparam int MCR_DTR_BIT  = 0;
    localparam int MCR_RTS_BIT  = 1;
    localparam int MCR_LOOP_BIT = 4;
    localparam int MSR_W        = 8;
    localparam int HS_W         = 4;

    // reset values
    localparam logic [IER_W-1:0] IER_RST = 4'h0;
    localparam logic [MCR_W-1:0] MCR_RST = 5'h00;
    localparam logic [NPORT-1:0] MASK_RST = 2'h0;

    // handshake inputs, ordered so msr = {~levels, change flags}
    typedef struct packed {
        logic carrier_detect_n;
        logic ring_indicator_n;
        logic data_set_ready_n;
        logic clear_to_send_n;
    } msi_hs_in_s;

    // handshake outputs, idle high
    typedef struct packed {
        logic request_to_send_n;
        logic terminal_ready_n;
    } msi_hs_out_s;

    localparam msi_hs_in_s  HS_IN_IDLE  = 4'hf;
    localparam msi_hs_out_s HS_OUT_IDLE = 2'h3;

endpackage : msi_pkg

// file: hw/msi_port.sv
// per-port handshake input sampling, levels and change flags
`timescale 1ns/1ps
module msi_port
    import msi_pkg::*;
(
    input  wire logic             clk_sys, // system clock
    input  wire logic             rst_b,   // async reset, active low
    input  wire logic             ce,      // clock enable
    input  wire msi_hs_in_s       pins_n,  // handshake inputs
    input  wire logic             rd_clr,  // status read, clears flags
    output logic [MSR_W-1:0]      modem_status_reg,     // modem status value
    output logic                  chg      // any input changed
);

    typedef struct packed {
        msi_hs_in_s      last_n;
        logic [HS_W-1:0] delta;
        logic            seen;
    } msi_port_st_s;

    msi_port_st_s    q;
    msi_port_st_s    nxt;
    logic [HS_W-1:0] rise;

    // low to high on an active-low pin; none before the first sample
    assign rise = q.seen ? (~q.last_n & pins_n) : '0;
    assign chg  = ce && q.seen && (pins_n != q.last_n);
    // levels are complemented, change flags in the low nibble
    assign modem_status_reg  = {~q.last_n, q.delta};

    // set wins over the read clear, so no edge is lost
    always_comb begin
        nxt = q;
        if (ce) begin
            nxt.last_n = pins_n;
            nxt.seen   = 1'b1;
            nxt.delta  = (q.delta & ~{HS_W{rd_clr}}) | rise;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{last_n: HS_IN_IDLE, delta: '0, seen: 1'b0};
        end else begin
            q <= nxt;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_cts_level;
        ce |=> modem_status_reg[4] == !$past(pins_n.clear_to_send_n);
    endproperty
    a_cts_level: assert property (p_cts_level)
        else $error("cts level bit wrong");

    property p_dsr_level;
        ce |=> modem_status_reg[5] == !$past(pins_n.data_set_ready_n);
    endproperty
    a_dsr_level: assert property (p_dsr_level)
        else $error("dsr level bit wrong");

    property p_dcd_level;
        ce |=> modem_status_reg[7] == !$past(pins_n.carrier_detect_n);
    endproperty
    a_dcd_level: assert property (p_dcd_level)
        else $error("dcd level bit wrong");

    property p_ri_level;
        ce |=> modem_status_reg[6] == !$past(pins_n.ring_indicator_n);
    endproperty
    a_ri_level: assert property (p_ri_level)
        else $error("ri level bit wrong");

    property p_cts_rise;
        (ce && q.seen && !q.last_n.clear_to_send_n
            && pins_n.clear_to_send_n) |=> modem_status_reg[0];
    endproperty
    a_cts_rise: assert property (p_cts_rise)
        else $error("cts rise not flagged");

    property p_dsr_rise;
        (ce && q.seen && !q.last_n.data_set_ready_n
            && pins_n.data_set_ready_n) |=> modem_status_reg[1];
    endproperty
    a_dsr_rise: assert property (p_dsr_rise)
        else $error("dsr rise not flagged");

    property p_dcd_rise;
        (ce && q.seen && !q.last_n.carrier_detect_n
            && pins_n.carrier_detect_n) |=> modem_status_reg[3];
    endproperty
    a_dcd_rise: assert property (p_dcd_rise)
        else $error("dcd rise not flagged");

    property p_ri_rise;
        (ce && q.seen && !q.last_n.ring_indicator_n
            && pins_n.ring_indicator_n) |=> modem_status_reg[2];
    endproperty
    a_ri_rise: assert property (p_ri_rise)
        else $error("ri rise not flagged");

    property p_read_clear;
        (ce && rd_clr && rise == '0) |=> modem_status_reg[3:0] == '0;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status read left change flags set");

endmodule : msi_port

// file: hw/msi_hs_drive.sv
// per-port request-to-send and terminal-ready output drivers
`timescale 1ns/1ps
module msi_hs_drive
    import msi_pkg::*;
(
    input  wire logic             clk_sys, // system clock
    input  wire logic             rst_b,   // async reset, active low
    input  wire logic             ce,      // clock enable
    input  wire logic [MCR_W-1:0] modem_control_reg,     // modem control value
    output msi_hs_out_s           hs_n     // registered outputs
);

    typedef struct packed {
        msi_hs_out_s out;
    } msi_drv_st_s;

    msi_drv_st_s q;
    msi_drv_st_s nxt;

    // loop mode forces both lines to their idle level
    always_comb begin
        nxt = q;
        if (ce) begin
            nxt.out.request_to_send_n =
                ~(modem_control_reg[MCR_RTS_BIT] & ~modem_control_reg[MCR_LOOP_BIT]);
            nxt.out.terminal_ready_n =
                ~(modem_control_reg[MCR_DTR_BIT] & ~modem_control_reg[MCR_LOOP_BIT]);
        end
    end

    // reset leaves both lines inactive high
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{out: HS_OUT_IDLE};
        end else begin
            q <= nxt;
        end
    end

    assign hs_n = q.out;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_rts_drive;
        ce |=> hs_n.request_to_send_n ==
            ($past(modem_control_reg[MCR_LOOP_BIT]) || !$past(modem_control_reg[MCR_RTS_BIT]));
    endproperty
    a_rts_drive: assert property (p_rts_drive)
        else $error("request to send output wrong");

    property p_dtr_drive;
        ce |=> hs_n.terminal_ready_n ==
            ($past(modem_control_reg[MCR_LOOP_BIT]) || !$past(modem_control_reg[MCR_DTR_BIT]));
    endproperty
    a_dtr_drive: assert property (p_dtr_drive)
        else $error("terminal ready output wrong");

endmodule : msi_hs_drive

// file: hw/msi_top.sv
// modem status input block for two serial ports, apb register slave
//
// What this block does
// - status bit 4 shows the complement of clear-to-send.
// - status bit 5 shows the complement of data-set-ready.
// - status bit 7 shows the complement of carrier-detect.
// - status bit 6 shows the complement of ring-indicator.
// - clear-to-send rising since last status read sets status bit 0.
// - data-set-ready rising since last status read sets status bit 1.
// - carrier-detect rising since last status read sets status bit 3.
// - ring-indicator rising since last status read sets status bit 2.
// - with enable bit 3 and the port's mask bit set, any handshake input change interrupts.
// - clear-to-send never gates or stalls the transmitter.
// - request-to-send follows control bit 1, idle on reset and loop.
// - terminal-ready follows control bit 0, idle on reset and loop.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module msi_top
    import msi_pkg::*;
(
    input  wire logic               clk_sys,   // 100 MHz system clock
    input  wire logic               rst_b,     // async reset, active low
    input  wire logic               ce,        // clock enable, freezes all
    input  wire logic               psel,      // apb select
    input  wire logic               penable,   // apb access phase
    input  wire logic               pwrite,    // apb write
    input  wire logic [ADDR_W-1:0]  paddr,     // apb byte address
    input  wire logic [DATA_W-1:0]  pwdata,    // apb write data
    output logic      [DATA_W-1:0]  prdata,    // apb read data
    output logic                    pready,    // apb ready
    output logic                    pslverr,   // apb error, unmapped
    input  wire msi_hs_in_s [NPORT-1:0]  hs_in_n,  // handshake inputs
    output msi_hs_out_s [NPORT-1:0]      hs_out_n, // handshake outputs
    output logic                    irq        // level interrupt
);

    typedef struct packed {
        logic [NPORT-1:0][IER_W-1:0] interrupt_enable_reg;
        logic [NPORT-1:0][MCR_W-1:0] modem_control_reg;
        logic [NPORT-1:0]            int_stat;
        logic [NPORT-1:0]            int_mask;
        logic [DATA_W-1:0]           prdata;
        logic                        pready;
        logic                        pslverr;
        logic                        irq;
    } msi_top_st_s;

    msi_top_st_s                 q;
    msi_top_st_s                 nxt;
    logic [NPORT-1:0][MSR_W-1:0] modem_status_reg;
    logic [NPORT-1:0]            chg;
    logic [NPORT-1:0]            rd_clr;
    logic [NPORT-1:0]            ier_msi;
    logic [NPORT-1:0]            ev;
    logic                        acc;
    logic                        done;
    logic                        in_port;
    logic                        port_idx;
    logic [REG_OFS_W-1:0]        reg_ofs;
    logic                        hit_ier;
    logic                        hit_mcr;
    logic                        hit_msr;
    logic                        hit_ist;
    logic                        hit_msk;
    logic                        hit_any;

    // one independent copy of input and output logic per port
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        msi_port u_port (
            .clk_sys (clk_sys),
            .rst_b   (rst_b),
            .ce      (ce),
            .pins_n  (hs_in_n[p]),
            .rd_clr  (rd_clr[p]),
            .modem_status_reg     (modem_status_reg[p]),
            .chg     (chg[p])
        );
        msi_hs_drive u_drive (
            .clk_sys (clk_sys),
            .rst_b   (rst_b),
            .ce      (ce),
            .modem_control_reg     (q.modem_control_reg[p]),
            .hs_n    (hs_out_n[p])
        );
        assign ier_msi[p] = q.interrupt_enable_reg[p][IER_MSI_BIT];
    end

    // clear-to-send is only reported; no transmit path is gated here

    // apb phases: first access cycle answers, second completes
    assign acc  = psel && penable && !q.pready;
    assign done = psel && penable && q.pready;

    // events only reach the interrupt when the port enables them
    assign ev = chg & ier_msi;

    // address decode; the port group repeats every stride
    always_comb begin
        in_port  = paddr < PORT_SPAN;
        port_idx = paddr[PORT_IDX_LSB];
        reg_ofs  = paddr[REG_OFS_W-1:0];
        hit_ier  = 1'b0;
        hit_mcr  = 1'b0;
        hit_msr  = 1'b0;
        hit_ist  = 1'b0;
        hit_msk  = 1'b0;
        if (in_port && reg_ofs == OFS_IER[REG_OFS_W-1:0]) begin
            hit_ier = 1'b1;
        end else if (in_port && reg_ofs == OFS_MCR[REG_OFS_W-1:0]) begin
            hit_mcr = 1'b1;
        end else if (in_port && reg_ofs == OFS_MSR[REG_OFS_W-1:0]) begin
            hit_msr = 1'b1;
        end else if (paddr == OFS_INT_STAT) begin
            hit_ist = 1'b1;
        end else if (paddr == OFS_INT_MASK) begin
            hit_msk = 1'b1;
        end
        hit_any = hit_ier | hit_mcr | hit_msr | hit_ist | hit_msk;
    end

    // read clear of the port status happens at the answering edge,
    // the same edge that captures prdata, so no flag slips between
    always_comb begin
        rd_clr = '0;
        if (ce && acc && !pwrite && hit_msr) begin
            rd_clr[port_idx] = 1'b1;
        end
    end

    // register file, interrupt status and bus answer
    always_comb begin
        nxt = q;
        if (ce) begin
            nxt.pready   = 1'b0;
            nxt.int_stat = q.int_stat | ev;
            if (acc) begin
                nxt.pready  = 1'b1;
                nxt.pslverr = !hit_any;
                nxt.prdata  = '0;
                if (hit_ier) begin
                    nxt.prdata[IER_W-1:0] = q.interrupt_enable_reg[port_idx];
                end else if (hit_mcr) begin
                    nxt.prdata[MCR_W-1:0] = q.modem_control_reg[port_idx];
                end else if (hit_msr) begin
                    nxt.prdata[MSR_W-1:0] = modem_status_reg[port_idx];
                end else if (hit_ist) begin
                    nxt.prdata[NPORT-1:0] = q.int_stat;
                    if (!pwrite) begin
                        // read clears, a same-cycle event survives
                        nxt.int_stat = ev;
                    end
                end else if (hit_msk) begin
                    nxt.prdata[NPORT-1:0] = q.int_mask;
                end
            end
            // writes land on the completing edge; status is read-only
            if (done && pwrite) begin
                if (hit_ier) begin
                    nxt.interrupt_enable_reg[port_idx] = pwdata[IER_W-1:0];
                end else if (hit_mcr) begin
                    nxt.modem_control_reg[port_idx] = pwdata[MCR_W-1:0];
                end else if (hit_msk) begin
                    nxt.int_mask = pwdata[NPORT-1:0];
                end
            end
            nxt.irq = |(nxt.int_stat & nxt.int_mask);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{interrupt_enable_reg: {NPORT{IER_RST}}, modem_control_reg: {NPORT{MCR_RST}},
                   int_stat: '0, int_mask: MASK_RST, prdata: '0,
                   pready: 1'b0, pslverr: 1'b0, irq: 1'b0};
        end else begin
            q <= nxt;
        end
    end

    // every output straight from a flop
    assign prdata  = q.prdata;
    assign pready  = q.pready;
    assign pslverr = q.pslverr;
    assign irq     = q.irq;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_change_irq;
        (ce && |(chg & ier_msi & q.int_mask)) |=> irq;
    endproperty
    a_change_irq: assert property (p_change_irq)
        else $error("enabled input change raised no interrupt");

    property p_no_enable_no_stat;
        (ce && ier_msi == '0 && !(acc && hit_ist))
            |=> q.int_stat == $past(q.int_stat);
    endproperty
    a_no_enable_no_stat: assert property (p_no_enable_no_stat)
        else $error("interrupt status moved without enable");

    property p_port_indep;
        (ce && acc && !pwrite && hit_msr)
            |-> rd_clr[!port_idx] == 1'b0;
    endproperty
    a_port_indep: assert property (p_port_indep)
        else $error("status read touched the other port");

    property p_msr_read_data;
        (ce && acc && !pwrite && hit_msr && !port_idx)
            |=> pready && prdata[MSR_W-1:0] == $past(modem_status_reg[0]);
    endproperty
    a_msr_read_data: assert property (p_msr_read_data)
        else $error("status read returned wrong value");

endmodule : msi_top

// file: test/msi_modem_model.sv
// far-side modem model driving the handshake lines of both ports
`timescale 1ns/1ps
module msi_modem_model
    import msi_pkg::*;
(
    input  wire logic             clk_sys,  // system clock
    input  wire logic             set_v,    // request to move the lines
    input  wire logic             set_port, // port whose lines move
    input  wire msi_hs_in_s       set_lvl,  // new active-low levels
    input  wire logic [1:0]       dly,      // extra cycles before moving
    output msi_hs_in_s [NPORT-1:0] pins_n   // lines into the device
);
    msi_hs_in_s [NPORT-1:0] lvl_r = {NPORT{HS_IN_IDLE}};

    // a slow modem moves its lines some cycles after being asked
    always @(posedge clk_sys) begin
        if (set_v) begin
            repeat (dly) @(posedge clk_sys);
            lvl_r[set_port] <= set_lvl;
        end
    end

    assign pins_n = lvl_r;
endmodule : msi_modem_model

// file: test/msi_top_test.sv
// self-checking bench for the modem status input block
`timescale 1ns/1ps
module msi_top_test
    import msi_pkg::*;
;
    logic                     clk_sys;
    logic                     rst_b;
    logic                     ce;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [ADDR_W-1:0]        paddr;
    logic [DATA_W-1:0]        pwdata;
    logic [DATA_W-1:0]        prdata;
    logic                     pready;
    logic                     pslverr;
    msi_hs_in_s [NPORT-1:0]   hs_in_n;
    msi_hs_out_s [NPORT-1:0]  hs_out_n;
    logic                     irq;
    logic                     set_v;
    logic                     set_port;
    msi_hs_in_s               set_lvl;
    logic [1:0]               dly;
    logic [32:0]              exp_q[$];
    logic [32:0]              msk_q[$];
    logic [32:0]              e_v;
    logic [32:0]              m_v;
    logic [3:0]               cur[NPORT];
    logic [3:0]               flg[NPORT];
    logic [NPORT-1:0]         ier_on;
    logic [NPORT-1:0]         msk;
    logic [NPORT-1:0]         ist;
    logic [4:0]               mv[6] = '{5'h01, 5'h02, 5'h03, 5'h13,
                                        5'h1f, 5'h00};
    int                       failures = 0;
    int                       tests_run = 0;

    msi_top msi_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hs_in_n(hs_in_n), .hs_out_n(hs_out_n),
        .irq(irq));

    msi_modem_model msi_modem_model_i (.clk_sys(clk_sys), .set_v(set_v),
        .set_port(set_port), .set_lvl(set_lvl), .dly(dly),
        .pins_n(hs_in_n));

    always #5 clk_sys = ~clk_sys;

    task check(input string nm, input logic [32:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task results;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // answers are judged where they appear, against the oldest note
    always @(posedge clk_sys) begin
        if (pready === 1'b1) begin
            e_v = exp_q.size() > 0 ? exp_q.pop_front() : 33'h0;
            m_v = msk_q.size() > 0 ? msk_q.pop_front() : 33'h1ffffffff;
            check("apb answer", {pslverr, prdata} & m_v, e_v & m_v);
        end
    end

    // one apb transfer; the wait for pready is bounded
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [32:0] e, input logic [32:0] m);
        int n;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function logic [7:0] pa(input int p, input logic [7:0] o);
        return o + (p != 0 ? PORT_STRIDE : 8'h00);
    endfunction : pa

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e}, 33'h1ffffffff);
    endtask : rd

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, 33'h100000000);
    endtask : wr

    task rd_msr(input int p);
        rd(pa(p, OFS_MSR), {24'h0, ~cur[p], flg[p]});
        flg[p] = 4'h0;
    endtask : rd_msr

    task rd_ist;
        rd(OFS_INT_STAT, {30'h0, ist});
        ist = '0;
    endtask : rd_ist

    // move one port's lines through the modem and update the model
    task pins(input int p, input logic [3:0] v, input int d);
        set_port <= p[0];
        set_lvl  <= v;
        dly      <= d[1:0];
        set_v    <= 1'b1;
        @(posedge clk_sys);
        set_v    <= 1'b0;
        repeat (d + 3) @(posedge clk_sys);
        flg[p] = flg[p] | (v & ~cur[p]);
        if (v != cur[p] && ier_on[p]) ist[p] = 1'b1;
        cur[p] = v;
        check("irq", 33'(irq), 33'(|(ist & msk)));
    endtask : pins

    initial begin
        #100us;
        failures++;
        results();
    end

    initial begin
        void'($urandom(32'h4dc4));
        clk_sys = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {set_v, set_port, dly} = '0;
        set_lvl = HS_IN_IDLE;
        cur = '{4'hf, 4'hf};
        flg = '{4'h0, 4'h0};
        {ier_on, msk, ist} = '0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check("out idle", 33'(hs_out_n), 33'({NPORT{HS_OUT_IDLE}}));
        // reset values, then unmapped and read-only places
        for (int p = 0; p < NPORT; p++) begin
            rd(pa(p, OFS_IER), 32'h0);
            rd(pa(p, OFS_MCR), 32'h0);
            rd_msr(p);
        end
        rd(OFS_INT_MASK, 32'h0);
        rd_ist();
        apb(1'b0, 8'h0c, 32'h0, 33'h100000000, 33'h1ffffffff);
        apb(1'b0, 8'h1c, 32'h0, 33'h100000000, 33'h1ffffffff);
        apb(1'b1, 8'h28, 32'h5, 33'h100000000, 33'h100000000);
        wr(OFS_MSR, 32'hff);
        rd_msr(0);
        // each line falls then rises; the other port must not see it
        for (int p = 0; p < NPORT; p++) begin
            for (int b = 0; b < 4; b++) begin
                pins(p, 4'hf ^ (4'h1 << b), 0);
                rd_msr(p);
                pins(p, 4'hf, 1);
                rd_msr(1 - p);
                rd_msr(p);
                rd_msr(p);
            end
        end
        // interrupt raised, cleared by read, masked, and gated per port
        wr(pa(0, OFS_IER), 32'h8);
        ier_on = 2'b01;
        wr(OFS_INT_MASK, 32'h3);
        msk = 2'b11;
        pins(0, 4'h7, 0);
        rd_ist();
        repeat (2) @(posedge clk_sys);
        check("irq clr", 33'(irq), 33'h0);
        wr(OFS_INT_MASK, 32'h2);
        msk = 2'b10;
        pins(0, 4'hf, 2);
        pins(1, 4'h3, 0);
        rd_ist();
        // control bits to the outputs, loop forces them idle
        for (int p = 0; p < NPORT; p++) begin
            foreach (mv[i]) begin
                wr(pa(p, OFS_MCR), 32'(mv[i]));
                repeat (2) @(posedge clk_sys);
                check("rts", 33'(hs_out_n[p][1]), 33'(!(mv[i][1] && !mv[i][4])));
                check("dtr", 33'(hs_out_n[p][0]), 33'(!(mv[i][0] && !mv[i][4])));
                rd(pa(p, OFS_MCR), 32'(mv[i]));
            end
        end
        wr(pa(1, OFS_MCR), 32'h3);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        check("out rst", 33'(hs_out_n), 33'({NPORT{HS_OUT_IDLE}}));
        rst_b <= 1'b1;
        {ier_on, msk, ist} = '0;
        flg = '{4'h0, 4'h0};
        repeat (3) @(posedge clk_sys);
        // random line patterns on both ports
        wr(pa(0, OFS_IER), 32'h8);
        wr(pa(1, OFS_IER), 32'h8);
        ier_on = 2'b11;
        wr(OFS_INT_MASK, 32'h3);
        msk = 2'b11;
        repeat (24) begin
            pins($urandom_range(1, 0), 4'($urandom), $urandom_range(2, 0));
            rd_msr(set_port);
            if ($urandom_range(1, 0) == 1) rd_ist();
        end
        rd_ist();
        repeat (4) @(posedge clk_sys);
        check("pending", 33'(exp_q.size()), 33'h0);
        results();
    end
endmodule : msi_top_test
